/* File: logic/watchdog_consts.vh */
// Purpose: constants for the watchdog and chip reset generator
// Assumes: 8-bit special register space, 16-bit instruction address
// Notes:   definitions only
`ifndef WATCHDOG_CONSTS_VH
`define WATCHDOG_CONSTS_VH

// register addresses in the special register space
`define WD_CTRL_ADDR        8'h34
`define WD_CODE_ADDR        8'h35

// watchdog_control field positions
`define WD_EN_BIT           3
`define WD_DTS_HI           2
`define WD_DTS_LO           1
`define WD_OUTSEL_BIT       0

// reset values
`define WD_EN_RST           1'b1
`define WD_DTS_RST          2'h0
`define WD_OUTSEL_RST       1'b1

// codes for watchdog_code_write
`define WD_CLEAR_CODE       8'h4E
`define WD_DISABLE_CODE     8'hB1

// overflow period exponents for code 00, step 2 per code
`define WD_HI_EXP_BASE      6'h19
`define WD_LO_EXP_BASE      6'h11

// reset output time exponent, in high-clock periods
`define RST_OUT_EXP         20

// address trap window for instruction fetches
`define TRAP_ADDR_LO        16'h0000
`define TRAP_ADDR_HI        16'h043F

// reset vector location
`define RESET_VECTOR_ADDR   16'hFFFE

// oscillator enable bits of system_control_two
`define HIGH_OSC_EN_BIT     7
`define LOW_OSC_EN_BIT      6

`endif

/* File: logic/reset_stretch.v */
// Purpose: holds an internal reset for 2^EXP clock periods after a trigger
// Assumes: sys_clk_i is the high-frequency clock
// Notes:   comes out of power-up busy, so one period may show at power-on
`timescale 1ns/1ns
`default_nettype none

module reset_stretch #(
    parameter EXP = 20
) (
    input  wire sys_clk_i,
    input  wire rst_n_i,
    input  wire trigger_i,
    output wire busy_o
);

    reg  [EXP:0] cnt_r;
    reg  [EXP:0] cnt_nxt;

    always @* begin
        cnt_nxt = cnt_r;
        if (trigger_i) begin
            cnt_nxt = {1'b0, {EXP{1'b0}}};
        end else if (!cnt_r[EXP]) begin
            cnt_nxt = cnt_r + {{EXP{1'b0}}, 1'b1};
        end
    end

    // RQ18: power-up starts one period
    always @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_r <= {1'b0, {EXP{1'b0}}};
        end else begin
            cnt_r <= cnt_nxt;
        end
    end

    assign busy_o = ~cnt_r[EXP];

endmodule // reset_stretch

`default_nettype wire

/* File: logic/watchdog_and_reset_gen.v */
// Purpose: watchdog timer with code-clear and chip reset generator
// Assumes: all inputs synchronous to sys_clk_i (the high-frequency clock)
// Notes:   reset pin is open drain, shown as input, output and enable
//
// Function
// RQ1: overflow action resets to chip reset; choice changes only once per reset
// RQ2: two-bit field picks 2^25..2^19 high or 2^17..2^11 low cycles
// RQ3: overflow without clear gives chip reset if select is 1, else interrupt
// RQ4: after select cleared to interrupt, writes setting it back are ignored
// RQ5: counter holds during stop, warm-up and idle, resumes from held count
// RQ6: code 4E clears counter, B1 is disable code, others do nothing
// RQ7: disable code works only when enable bit already 0
// RQ8: disabling the watchdog clears its counter to zero
// RQ9: enable bit is bit 3, resets to 1, writing 1 enables
// RQ10: interrupt ignores enable flags, waits while watchdog or soft irq in service
// RQ11: watchdog reset drives pin low for 2^20 high-clock periods
// RQ12: watchdog reset in slow mode turns high oscillator on, times in fc
// RQ13: outside party holds reset pin low at least 12 high-clock periods
// RQ14: reset pin high releases reset, execution starts from vector at FFFE
// RQ15: instruction fetch from 0000..043F causes address-trap reset of 2^20
// RQ16: both oscillator enables zero gives reset, keeps oscillation, pin low
// RQ17: any reset loads vector, clears cpu state flags, enables watchdog
// RQ18: internal reset logic may pull pin low one period at power-up
// RQ19: software disables or clears watchdog around stop mode
// RQ20: control register write-only, whole-byte stores, no read-modify-write
// RQ21: all sources merge into one active-low reset; only the internal sources go through the shared duration counter
`timescale 1ns/1ns
`default_nettype none
`include "watchdog_consts.vh"

module watchdog_and_reset_gen #(
    parameter [5:0] HI_EXP_BASE = `WD_HI_EXP_BASE,
    parameter [5:0] LO_EXP_BASE = `WD_LO_EXP_BASE,
    parameter       RST_EXP     = `RST_OUT_EXP
) (
    input  wire        sys_clk_i,
    input  wire        rst_n_i,
    // register write port from the cpu core
    input  wire        wr_en_i,
    input  wire [7:0]  wr_addr_i,
    input  wire [7:0]  wr_data_i,
    // instruction fetch monitor
    input  wire        fetch_valid_i,
    input  wire [15:0] fetch_addr_i,
    // system state
    input  wire [7:0]  system_control_two_i,
    input  wire        slow_mode_i,
    input  wire        low_clk_tick_i,
    input  wire        stop_mode_i,
    input  wire        idle_mode_i,
    // interrupt handshake
    input  wire        wd_irq_ack_i,
    input  wire        sw_irq_in_service_i,
    input  wire        nmi_return_instr_i,
    output wire        wd_interrupt_request_o,
    // reset pin, open drain
    input  wire        reset_pin_i,
    output wire        reset_pin_o,
    output wire        reset_pin_oe_o,
    // chip reset and initial state
    output wire        chip_reset_n_o,
    output wire        high_osc_force_on_o,
    output reg         pc_load_vector_o,
    output reg  [15:0] vector_addr_o,
    output reg         wd_running_o
);

    localparam CNT_W = (HI_EXP_BASE > LO_EXP_BASE) ? HI_EXP_BASE : LO_EXP_BASE;

    // control state
    reg              wd_enable_bit_r;
    reg              wd_enable_bit_nxt;
    reg  [1:0]       detect_time_select_r;
    reg  [1:0]       detect_time_select_nxt;
    reg              overflow_action_select_r;
    reg              overflow_action_select_nxt;
    reg              running_r;
    reg              running_nxt;
    reg  [CNT_W-1:0] cnt_r;
    reg  [CNT_W-1:0] cnt_nxt;
    reg              pending_r;
    reg              pending_nxt;
    reg              in_service_r;
    reg              in_service_nxt;
    reg              chip_rst_d_r;

    // decode and timing
    wire             ctrl_wr;
    wire             code_wr;
    wire             clear_code;
    wire             disable_code;
    wire             freeze;
    wire             tick;
    reg  [5:0]       exp_sel;
    reg  [CNT_W-1:0] limit;
    wire             overflow;
    wire             wd_reset_evt;
    wire             trap_evt;
    wire             osc_dead;
    wire             stretch_busy;
    wire             chip_rst;

    // RQ20: whole-byte writes only, nothing readable
    assign ctrl_wr      = wr_en_i & (wr_addr_i == `WD_CTRL_ADDR);
    assign code_wr      = wr_en_i & (wr_addr_i == `WD_CODE_ADDR);
    // RQ6: only two codes are recognised
    assign clear_code   = code_wr & (wr_data_i == `WD_CLEAR_CODE);
    assign disable_code = code_wr & (wr_data_i == `WD_DISABLE_CODE);

    // RQ5: hold in stop, warm-up and idle
    assign freeze = stop_mode_i | idle_mode_i;

    // RQ2: high clock counts every cycle, low clock on its tick
    assign tick = running_r & ~freeze & (slow_mode_i ? low_clk_tick_i : 1'b1);

    // RQ2: period select
    always @* begin
        if (slow_mode_i) begin
            exp_sel = LO_EXP_BASE - {3'h0, detect_time_select_r, 1'b0};
        end else begin
            exp_sel = HI_EXP_BASE - {3'h0, detect_time_select_r, 1'b0};
        end
        limit = ~({CNT_W{1'b1}} << exp_sel);
    end

    // RQ3: overflow at the top of the selected period
    assign overflow     = tick & (cnt_r == limit) & ~clear_code;
    assign wd_reset_evt = overflow & overflow_action_select_r;

    // RQ15: fetch from ram or register area
    assign trap_evt = fetch_valid_i
                    & (fetch_addr_i >= `TRAP_ADDR_LO)
                    & (fetch_addr_i <= `TRAP_ADDR_HI);

    // RQ16: both oscillator enables low
    assign osc_dead = ~system_control_two_i[`HIGH_OSC_EN_BIT]
                    & ~system_control_two_i[`LOW_OSC_EN_BIT];

    // RQ11: shared reset duration counter
    reset_stretch #(
        .EXP       (RST_EXP)
    ) u_stretch (
        .sys_clk_i (sys_clk_i),
        .rst_n_i   (rst_n_i),
        .trigger_i (wd_reset_evt | trap_evt | osc_dead),
        .busy_o    (stretch_busy)
    );

    // RQ21: one active-low reset from all sources
    assign chip_rst       = ~reset_pin_i | stretch_busy | osc_dead;
    assign chip_reset_n_o = ~chip_rst;

    // RQ16: internal sources pull the pin low
    assign reset_pin_o    = 1'b0;
    assign reset_pin_oe_o = stretch_busy | osc_dead;

    // RQ12: high oscillator stays on while internal reset is timed
    assign high_osc_force_on_o = stretch_busy | osc_dead;

    // control register next state
    always @* begin
        wd_enable_bit_nxt          = wd_enable_bit_r;
        detect_time_select_nxt     = detect_time_select_r;
        overflow_action_select_nxt = overflow_action_select_r;
        running_nxt                = running_r;
        if (ctrl_wr) begin
            wd_enable_bit_nxt      = wr_data_i[`WD_EN_BIT];
            detect_time_select_nxt = wr_data_i[`WD_DTS_HI:`WD_DTS_LO];
            // RQ4: select can only fall to interrupt mode
            overflow_action_select_nxt = overflow_action_select_r
                                       & wr_data_i[`WD_OUTSEL_BIT];
            // RQ9: writing 1 enables
            if (wr_data_i[`WD_EN_BIT]) begin
                running_nxt = 1'b1;
            end
        end
        // RQ7: disable code only with enable bit already 0
        if (disable_code && !wd_enable_bit_r) begin
            running_nxt = 1'b0;
        end
    end

    // counter next state
    always @* begin
        cnt_nxt = cnt_r;
        if (tick) begin
            if (cnt_r == limit) begin
                cnt_nxt = {CNT_W{1'b0}};
            end else begin
                cnt_nxt = cnt_r + {{(CNT_W-1){1'b0}}, 1'b1};
            end
        end
        // RQ6: clear code restarts the count
        if (clear_code) begin
            cnt_nxt = {CNT_W{1'b0}};
        end
        // RQ8: disabled watchdog holds zero
        if (!running_nxt) begin
            cnt_nxt = {CNT_W{1'b0}};
        end
    end

    // interrupt request and service tracking
    always @* begin
        pending_nxt    = pending_r;
        in_service_nxt = in_service_r;
        if (wd_irq_ack_i && wd_interrupt_request_o) begin
            pending_nxt    = 1'b0;
            in_service_nxt = 1'b1;
        end
        if (nmi_return_instr_i) begin
            in_service_nxt = 1'b0;
        end
        // RQ3: interrupt mode overflow, set wins over acceptance
        if (overflow && !overflow_action_select_r) begin
            pending_nxt = 1'b1;
        end
    end

    // RQ10: pseudo non-maskable, held off while a previous one is serviced
    assign wd_interrupt_request_o = pending_r & ~in_service_r & ~sw_irq_in_service_i;

    always @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wd_enable_bit_r          <= `WD_EN_RST;
            detect_time_select_r     <= `WD_DTS_RST;
            overflow_action_select_r <= `WD_OUTSEL_RST;
            running_r                <= 1'b1;
            cnt_r                    <= {CNT_W{1'b0}};
            pending_r                <= 1'b0;
            in_service_r             <= 1'b0;
        end else if (chip_rst) begin
            // RQ17: any reset enables the watchdog
            // RQ1: reset selects chip reset action
            wd_enable_bit_r          <= `WD_EN_RST;
            detect_time_select_r     <= `WD_DTS_RST;
            overflow_action_select_r <= `WD_OUTSEL_RST;
            running_r                <= 1'b1;
            cnt_r                    <= {CNT_W{1'b0}};
            pending_r                <= 1'b0;
            in_service_r             <= 1'b0;
        end else begin
            wd_enable_bit_r          <= wd_enable_bit_nxt;
            detect_time_select_r     <= detect_time_select_nxt;
            overflow_action_select_r <= overflow_action_select_nxt;
            running_r                <= running_nxt;
            cnt_r                    <= cnt_nxt;
            pending_r                <= pending_nxt;
            in_service_r             <= in_service_nxt;
        end
    end

    // RQ14: vector load on release of reset
    always @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            chip_rst_d_r     <= 1'b1;
            pc_load_vector_o <= 1'b0;
            vector_addr_o    <= `RESET_VECTOR_ADDR;
            wd_running_o     <= 1'b1;
        end else begin
            chip_rst_d_r     <= chip_rst;
            pc_load_vector_o <= chip_rst_d_r & ~chip_rst;
            vector_addr_o    <= `RESET_VECTOR_ADDR;
            wd_running_o     <= running_nxt & ~chip_rst;
        end
    end

endmodule // watchdog_and_reset_gen

`default_nettype wire

/* File: testbench/wd_checker.sv */
// Purpose: port-level checks for watchdog_and_reset_gen
// Assumes: one clock domain, reset rst_n_i
// Notes:   bound to the design top module
`timescale 1ns/1ns
`default_nettype none
module wd_checker #(
    parameter RST_EXP = 20
) (
    input wire        sys_clk_i, rst_n_i, fetch_valid_i,
    input wire [15:0] fetch_addr_i, vector_addr_o,
    input wire [7:0]  system_control_two_i,
    input wire        wd_irq_ack_i, sw_irq_in_service_i, wd_interrupt_request_o,
    input wire        reset_pin_i, reset_pin_o, reset_pin_oe_o,
    input wire        chip_reset_n_o, high_osc_force_on_o, pc_load_vector_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);
    reg  [31:0] oe_cnt_r;
    reg         dead_seen_r;
    wire        osc_dead = system_control_two_i[7:6] == 2'b00;
    // length of each pin pull, and whether osc-dead ever stretched one
    always @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            oe_cnt_r    <= 32'h0000_0000;
            dead_seen_r <= 1'b0;
        end else begin
            oe_cnt_r    <= reset_pin_oe_o ? oe_cnt_r + 32'h0000_0001 : 32'h0000_0000;
            dead_seen_r <= dead_seen_r | osc_dead;
        end
    end
    sequence trap_fetch;
        fetch_valid_i && fetch_addr_i <= 16'h043F && chip_reset_n_o;
    endsequence
    sequence pin_held;
        reset_pin_oe_o ##1 reset_pin_oe_o;
    endsequence
    a_trap_pulls_pin: assert property (trap_fetch |=> pin_held)
        else $error("trap fetch did not pull the pin");
    a_pin_pull_length: assert property ($fell(reset_pin_oe_o) && !dead_seen_r |->
        oe_cnt_r == 2**RST_EXP) else $error("pin pull length wrong");
    a_osc_dead_pin: assert property (osc_dead |-> reset_pin_oe_o && high_osc_force_on_o)
        else $error("dead oscillator not handled");
    a_pin_drives_low: assert property (reset_pin_oe_o |-> !reset_pin_o)
        else $error("pin driven high");
    a_pin_resets_chip: assert property (!reset_pin_i |-> !chip_reset_n_o)
        else $error("low pin did not reset chip");
    a_sw_holds_irq: assert property (sw_irq_in_service_i |-> !wd_interrupt_request_o)
        else $error("request while soft irq in service");
    a_ack_drops_irq: assert property (wd_interrupt_request_o && wd_irq_ack_i |=>
        !wd_interrupt_request_o) else $error("request stayed after ack");
    a_osc_forced_on: assert property (reset_pin_oe_o |-> high_osc_force_on_o)
        else $error("high oscillator off during reset");
    a_vector_load: assert property ($rose(chip_reset_n_o) |-> ##[0:2]
        (pc_load_vector_o && vector_addr_o == 16'hFFFE)) else $error("no vector load");
endmodule // wd_checker
bind watchdog_and_reset_gen wd_checker #(.RST_EXP(RST_EXP)) wd_checker_inst (
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .fetch_valid_i(fetch_valid_i),
    .fetch_addr_i(fetch_addr_i), .vector_addr_o(vector_addr_o),
    .system_control_two_i(system_control_two_i), .wd_irq_ack_i(wd_irq_ack_i),
    .sw_irq_in_service_i(sw_irq_in_service_i), .wd_interrupt_request_o(wd_interrupt_request_o),
    .reset_pin_i(reset_pin_i), .reset_pin_o(reset_pin_o), .reset_pin_oe_o(reset_pin_oe_o),
    .chip_reset_n_o(chip_reset_n_o), .high_osc_force_on_o(high_osc_force_on_o),
    .pc_load_vector_o(pc_load_vector_o));
`default_nettype wire

/* File: testbench/ext_reset_model.sv */
// Purpose: reset pin wire with pull-up and an external reset source
// Assumes: hold_req_i is a one-cycle request
// Notes:   pin level merges the device pull and the outside pull
`timescale 1ns/1ns
`default_nettype none
module ext_reset_model (
    input  wire sys_clk_i,
    input  wire hold_req_i,
    input  wire reset_pin_oe_i,
    output wire reset_pin_o
);
    reg [3:0] hold_cnt_r = 4'h0;
    always @(posedge sys_clk_i) begin
        if (hold_req_i)
            hold_cnt_r <= 4'hC;
        else if (hold_cnt_r != 4'h0)
            hold_cnt_r <= hold_cnt_r - 4'h1;
    end
    assign reset_pin_o = !(reset_pin_oe_i || hold_cnt_r != 4'h0);
endmodule // ext_reset_model
`default_nettype wire

/* File: testbench/watchdog_and_reset_gen_tb_top.sv */
// Purpose: directed tests of watchdog_and_reset_gen
// Assumes: periods shortened through parameters
// Notes:   low clock tick every 4 system cycles
`timescale 1ns/1ns
`default_nettype none
module watchdog_and_reset_gen_tb_top;
    localparam int RX = 4;
    reg clk = 0, rst_n = 0, wr_en = 0, fv = 0, slow = 0, tick = 0, stp = 0, idl = 0;
    reg ack = 0, sw = 0, ret = 0, hold = 0;
    reg  [7:0]  wa = 8'h00, wd = 8'h00, sys2 = 8'hC0;
    reg  [15:0] fa = 16'h0000;
    wire        req, pin, pin_o, oe, crn, osc_on, pcl, run;
    wire [15:0] vec;
    int error_cnt = 0, checks_done = 0, n = 0, tc = 0;
    always #5 clk = ~clk;
    always @(posedge clk) begin
        #1;
        tc++;
        tick = (tc % 4 == 0);
    end
    watchdog_and_reset_gen #(.HI_EXP_BASE(6'h08), .LO_EXP_BASE(6'h07), .RST_EXP(RX))
        watchdog_and_reset_gen_inst (.sys_clk_i(clk), .rst_n_i(rst_n), .wr_en_i(wr_en),
        .wr_addr_i(wa), .wr_data_i(wd), .fetch_valid_i(fv), .fetch_addr_i(fa),
        .system_control_two_i(sys2), .slow_mode_i(slow), .low_clk_tick_i(tick),
        .stop_mode_i(stp), .idle_mode_i(idl), .wd_irq_ack_i(ack), .sw_irq_in_service_i(sw),
        .nmi_return_instr_i(ret), .wd_interrupt_request_o(req), .reset_pin_i(pin),
        .reset_pin_o(pin_o), .reset_pin_oe_o(oe), .chip_reset_n_o(crn),
        .high_osc_force_on_o(osc_on), .pc_load_vector_o(pcl), .vector_addr_o(vec),
        .wd_running_o(run));
    ext_reset_model ext_reset_model_inst (.sys_clk_i(clk), .hold_req_i(hold),
        .reset_pin_oe_i(oe), .reset_pin_o(pin));
    task chk(input [31:0] seen, input [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task cyc(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask
    task tend(input string s);
        $display("test %s done, errors so far %0d", s, error_cnt);
    endtask
    task wr(input [7:0] a, input [7:0] d);
        wa = a;
        wd = d;
        wr_en = 1;
        cyc(1);
        wr_en = 0;
        cyc(1);
    endtask
    task rel;
        n = 0;
        while (crn !== 1'b1 && n < 5000) begin
            cyc(1);
            n++;
        end
        chk(n < 5000, 1);
    endtask
    task oe_len;
        n = 0;
        while (oe === 1'b1 && n < 100) begin
            cyc(1);
            n++;
        end
    endtask
    task meas(input int frz);
        n = 0;
        while (req !== 1'b1 && n < 2000) begin
            cyc(1);
            n++;
        end
        ack = 1;
        cyc(1);
        ack = 0;
        ret = 1;
        cyc(1);
        ret = 0;
        n = 2;
        if (frz > 0) begin
            stp = 1;
            repeat (frz) begin cyc(1); n++; end
            stp = 0;
            idl = 1;
            repeat (frz) begin cyc(1); n++; end
            idl = 0;
        end
        while (req !== 1'b1 && n < 2000) begin
            cyc(1);
            n++;
        end
    endtask
    task complete_run;
        $display("checks_done=%0d error_cnt=%0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge clk);
        #1;
        rst_n = 1;
        rel;
        cyc(2);
        chk(run, 1);
        tend("power_up");
        wr(8'h34, 8'h0E);
        for (int i = 3; i > 0; i--) begin
            wr(8'h34, {4'h1, i[1:0], 1'b0});
            wr(8'h35, 8'h4E);
            meas(0);
            meas(0);
            chk(n, 1 << (8 - 2 * i));
        end
        meas(5);
        chk(n, 74);
        sw = 1;
        cyc(70);
        chk(req, 0);
        sw = 0;
        cyc(1);
        chk(req, 1);
        wr(8'h35, 8'h4E);
        stp = 1;
        cyc(3);
        stp = 0;
        wr(8'h35, 8'h4E);
        chk(run, 1);
        slow = 1;
        wr(8'h34, 8'h0C);
        wr(8'h35, 8'h4E);
        meas(0);
        meas(0);
        chk(n, 32);
        slow = 0;
        tend("irq_periods");
        wr(8'h34, 8'h0F);
        wr(8'h35, 8'h4E);
        meas(0);
        meas(0);
        chk(n, 4);
        chk(oe, 0);
        wr(8'h35, 8'hB1);
        chk(run, 1);
        wr(8'h34, 8'h06);
        wr(8'h35, 8'hB1);
        chk(run, 0);
        wr(8'h34, 8'h08);
        wr(8'h36, 8'h06);
        chk(run, 1);
        tend("select_disable");
        fa = 16'h0440;
        fv = 1;
        cyc(1);
        fv = 0;
        cyc(1);
        chk(oe, 0);
        slow = 1;
        fa = 16'h043F;
        fv = 1;
        cyc(1);
        fv = 0;
        chk(oe, 1);
        oe_len;
        chk(n, 2 ** RX);
        rel;
        n = 0;
        while (oe !== 1'b1 && n < 700) begin
            cyc(1);
            n++;
        end
        chk(n >= 510 && n <= 520, 1);
        chk(osc_on, 1);
        oe_len;
        chk(n, 2 ** RX);
        slow = 0;
        rel;
        tend("trap_and_overflow");
        hold = 1;
        cyc(1);
        hold = 0;
        cyc(6);
        chk(crn, 0);
        rel;
        cyc(3);
        chk(run, 1);
        sys2 = 8'h00;
        cyc(3);
        chk(oe, 1);
        chk(crn, 0);
        sys2 = 8'hC0;
        cyc(1);
        oe_len;
        rel;
        cyc(3);
        chk(run, 1);
        tend("external_and_osc");
        complete_run;
    end
    initial begin
        repeat (60000) @(posedge clk);
        error_cnt++;
        complete_run;
    end
endmodule // watchdog_and_reset_gen_tb_top
`default_nettype wire
